// ---- design/bea_ctrl.sv ----
// nvm byte access controller: registers, sequencing, stalls, storage
`timescale 1ns/1ns
`include "bea_regs.svh"
module bea_ctrl #(
  parameter int DEPTH = 64,
  parameter int OSC_KHZ = `BEA_OSC_KHZ
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic osc_tick,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic global_int_en,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  output logic ready_irq
);
  localparam int ATOMIC_TICKS = (`BEA_ATOMIC_US * OSC_KHZ) / 1000;
  localparam int SPLIT_TICKS = (`BEA_SPLIT_US * OSC_KHZ) / 1000;

  logic [7:0] mem [DEPTH];
  logic [5:0] nvm_byte_address_r;
  logic [7:0] nvm_byte_data_r;
  logic [1:0] programming_mode_field_r;
  logic ready_interrupt_enable_r;
  logic [2:0] mpen_cnt_r;
  logic program_enable_busy_r;
  logic [2:0] stall_cnt_r;
  logic [5:0] op_addr_r;
  logic [7:0] op_data_r;
  logic [1:0] op_mode_r;
  bea_pkg::bea_state_t state_r;
  bea_prog_if pif ();

  logic wr_addr, wr_data, wr_ctrl, go_prog, go_read;

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic logic hit(input logic [1:0] a, input logic [1:0] off);
    hit = io_wr && (a == off);
  endfunction : hit

  assign wr_addr = hit(io_addr, `BEA_OFF_ADDR);
  assign wr_data = hit(io_addr, `BEA_OFF_DATA);
  assign wr_ctrl = hit(io_addr, `BEA_OFF_CTRL);
  // writing zero to a strobe bit is a no-op
  assign go_prog = wr_ctrl && io_wdata[`BEA_BIT_PEN] && // [RULE_18]
                   (mpen_cnt_r != 3'h0) && !program_enable_busy_r &&
                   (programming_mode_field_r != 2'h3); // [RULE_08]
  assign go_read = wr_ctrl && io_wdata[`BEA_BIT_RDSTB] &&
                   !program_enable_busy_r && !go_prog; // [RULE_12]

  // ****************************************************************
  // address and data registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (wr_addr && !program_enable_busy_r)
      nvm_byte_address_r <= io_wdata[5:0]; // [RULE_01] [RULE_12]
  end

  always_ff @(posedge mclk) begin
    if (go_read)
      nvm_byte_data_r <= mem[nvm_byte_address_r]; // [RULE_02] [RULE_11]
    else if (wr_data)
      nvm_byte_data_r <= io_wdata; // [RULE_02]
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      if (!program_enable_busy_r)
        programming_mode_field_r <= `BEA_MODE_RESET; // [RULE_05]
    end else if (wr_ctrl && !program_enable_busy_r && !go_prog) begin
      // the starting write keeps the mode the operation runs with
      programming_mode_field_r <=
        io_wdata[`BEA_BIT_PM_HI:`BEA_BIT_PM_LO]; // [RULE_04]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst)
      ready_interrupt_enable_r <= 1'b0;
    else if (wr_ctrl)
      ready_interrupt_enable_r <= io_wdata[`BEA_BIT_RIE];
  end

  // window of four cycles after master enable is set
  always_ff @(posedge mclk) begin
    if (rst)
      mpen_cnt_r <= 3'h0;
    else if (wr_ctrl && io_wdata[`BEA_BIT_MPEN])
      mpen_cnt_r <= 3'(`BEA_MPEN_WINDOW); // [RULE_07]
    else if (mpen_cnt_r != 3'h0)
      mpen_cnt_r <= mpen_cnt_r - 3'h1; // [RULE_07]
  end

  // ****************************************************************
  // programming sequence; not reset so it survives a reset
  // ****************************************************************
  assign pif.start = go_prog;
  assign pif.ticks = (programming_mode_field_r == 2'h0) ?
                     32'(ATOMIC_TICKS) : 32'(SPLIT_TICKS); // [RULE_03]

  always_ff @(posedge mclk) begin
    if (go_prog) begin
      op_addr_r <= nvm_byte_address_r;
      op_data_r <= nvm_byte_data_r;
      op_mode_r <= programming_mode_field_r;
      program_enable_busy_r <= 1'b1; // [RULE_09]
      state_r <= bea_pkg::BEA_ST_PROG;
    end else begin
      case (state_r)
        bea_pkg::BEA_ST_PROG: begin
          if (pif.done) begin
            state_r <= bea_pkg::BEA_ST_IDLE;
            program_enable_busy_r <= 1'b0; // [RULE_09] [RULE_15]
          end
        end
        bea_pkg::BEA_ST_IDLE: program_enable_busy_r <= 1'b0;
        default: begin
          state_r <= bea_pkg::BEA_ST_IDLE;
          program_enable_busy_r <= 1'b0;
        end
      endcase
    end
  end

  // storage update at the end of the timed operation
  always_ff @(posedge mclk) begin
    if (state_r == bea_pkg::BEA_ST_PROG && pif.done) begin
      case (op_mode_r)
        2'h0: mem[op_addr_r] <= op_data_r; // [RULE_03]
        2'h1: mem[op_addr_r] <= `BEA_ERASED;
        2'h2: begin
          // only an erased cell takes the byte; otherwise lost
          if (mem[op_addr_r] == `BEA_ERASED)
            mem[op_addr_r] <= op_data_r;
          else
            mem[op_addr_r] <= 8'hXX; // [RULE_16]
        end
        default: mem[op_addr_r] <= mem[op_addr_r];
      endcase
    end
  end

  bea_prog_timer u_timer (
    .mclk(mclk),
    .osc_tick(osc_tick),
    .pif(pif)
  );

  // ****************************************************************
  // processor stall and outputs
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst)
      stall_cnt_r <= 3'h0;
    else if (go_prog)
      stall_cnt_r <= 3'(`BEA_PROG_STALL); // [RULE_10]
    else if (go_read)
      stall_cnt_r <= 3'(`BEA_READ_STALL); // [RULE_11]
    else if (stall_cnt_r != 3'h0)
      stall_cnt_r <= stall_cnt_r - 3'h1;
  end

  always_ff @(posedge mclk) begin
    if (rst)
      cpu_stall <= 1'b0;
    else
      cpu_stall <= go_prog || go_read || (stall_cnt_r > 3'h1);
  end

  always_ff @(posedge mclk) begin
    if (rst)
      ready_irq <= 1'b0;
    else
      ready_irq <= ready_interrupt_enable_r && global_int_en &&
                   !program_enable_busy_r && !go_prog; // [RULE_06]
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      case (io_addr)
        `BEA_OFF_ADDR: io_rdata <= {2'h0, nvm_byte_address_r};
        `BEA_OFF_DATA: io_rdata <= nvm_byte_data_r;
        `BEA_OFF_CTRL: io_rdata <= {2'h0, programming_mode_field_r,
                                    ready_interrupt_enable_r,
                                    mpen_cnt_r != 3'h0,
                                    program_enable_busy_r,
                                    1'b0}; // [RULE_18]
        default: io_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  // halt lengths as the core sees them
  sequence read_halt_s;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence : read_halt_s

  sequence prog_halt_s;
    cpu_stall [*2] ##1 !cpu_stall;
  endsequence : prog_halt_s

  // master window open for four cycles, then shut
  sequence mpen_open_s;
    (mpen_cnt_r != 3'h0) [*4];
  endsequence : mpen_open_s

  sequence mpen_shut_s;
    (mpen_cnt_r == 3'h0 || $past(wr_ctrl));
  endsequence : mpen_shut_s

  stall_len_a: assert property ( // [RULE_11]
    @(posedge mclk) disable iff (rst)
    go_read |=> read_halt_s)
    else $error("read stall length wrong");
  prog_stall_a: assert property ( // [RULE_10]
    @(posedge mclk) disable iff (rst)
    go_prog |=> prog_halt_s)
    else $error("program stall length wrong");
  mpen_clear_a: assert property ( // [RULE_07]
    @(posedge mclk) disable iff (rst)
    (wr_ctrl && io_wdata[`BEA_BIT_MPEN] && !go_prog) |=>
    mpen_open_s ##1 mpen_shut_s)
    else $error("master enable not cleared");
  busy_set_a: assert property ( // [RULE_09]
    @(posedge mclk) disable iff (rst)
    go_prog |=> program_enable_busy_r)
    else $error("busy not set on start");
  mode_hold_a: assert property ( // [RULE_04]
    @(posedge mclk) disable iff (rst)
    program_enable_busy_r |=> $stable(programming_mode_field_r))
    else $error("mode changed while busy");
  addr_hold_a: assert property ( // [RULE_12]
    @(posedge mclk) disable iff (rst)
    program_enable_busy_r |=> $stable(nvm_byte_address_r))
    else $error("address changed while busy");
  no_start_a: assert property ( // [RULE_08]
    @(posedge mclk) disable iff (rst)
    (wr_ctrl && io_wdata[`BEA_BIT_PEN] && mpen_cnt_r == 3'h0 &&
    !program_enable_busy_r) |=> !program_enable_busy_r)
    else $error("start without master enable");
  irq_busy_a: assert property ( // [RULE_06]
    @(posedge mclk) disable iff (rst)
    program_enable_busy_r |=> !ready_irq)
    else $error("ready irq while busy");
endmodule : bea_ctrl

// ---- design/bea_pkg.sv ----
// types shared by the nvm access block
package bea_pkg;
  typedef enum logic [1:0] {
    BEA_PM_ATOMIC,
    BEA_PM_ERASE,
    BEA_PM_WRITE,
    BEA_PM_RSVD
  } bea_mode_t;

  typedef enum logic [1:0] {
    BEA_ST_IDLE,
    BEA_ST_PROG,
    BEA_ST_DONE
  } bea_state_t;
endpackage : bea_pkg

// ---- design/bea_prog_if.sv ----
// handshake between the control logic and the programming timer
`timescale 1ns/1ns
interface bea_prog_if;
  logic start;
  logic [31:0] ticks;
  logic done;
  modport ctrl (output start, output ticks, input done);
  modport timer (input start, input ticks, output done);
endinterface : bea_prog_if

// ---- design/bea_prog_timer.sv ----
// programming duration timer on calibrated oscillator ticks
`timescale 1ns/1ns
module bea_prog_timer (
  input wire logic mclk,
  input wire logic osc_tick,
  bea_prog_if.timer pif
);
  logic [31:0] cnt_r;
  logic run_r;

  // deliberately no reset: an operation must outlive a reset
  // run flag is only trusted once a start has loaded it
  always_ff @(posedge mclk) begin
    pif.done <= 1'b0;
    if (pif.start) begin
      cnt_r <= pif.ticks;
      run_r <= 1'b1;
    end else if (run_r && osc_tick) begin // [RULE_17]
      if (cnt_r <= 32'h1) begin
        run_r <= 1'b0;
        pif.done <= 1'b1;
      end
      cnt_r <= cnt_r - 32'h1;
    end
  end
endmodule : bea_prog_timer

// ---- design/bea_regs.svh ----
// register offsets, field positions and timing constants of the nvm access block
// Behaviour
// (RULE_01) address bits 5:0 pick one of 64 bytes; bits 7:6 read zero
// (RULE_02) data register feeds programming and receives fetched byte on read
// (RULE_03) mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms
// (RULE_04) mode field writes ignored while program enable is set
// (RULE_05) reset clears mode to 00 unless programming still runs
// (RULE_06) ready interrupt held while enable, global flag and not busy
// (RULE_07) master program enable clears itself four cycles after set
// (RULE_08) program enable starts only within four cycles of master enable
// (RULE_09) program enable stays set as busy until access time elapses
// (RULE_10) a started programming operation stalls the processor two cycles
// (RULE_11) read strobe loads data register and stalls processor four cycles
// (RULE_12) during programming reads are refused and address is frozen
// (RULE_13) software polls busy before loading address and reading
// (RULE_14) software loads address, data, mode, then master, then enable
// (RULE_15) reset during programming lets the operation finish
// (RULE_16) write-only on unerased byte leaves content undefined
// (RULE_17) programming time counted on calibrated oscillator ticks
// (RULE_18) read strobe self-clears; writing zero to strobes does nothing
`ifndef BEA_REGS_SVH
`define BEA_REGS_SVH

// ****************************************************************
// register offsets inside the block's I/O window
// ****************************************************************
`define BEA_OFF_ADDR 2'h0
`define BEA_OFF_DATA 2'h1
`define BEA_OFF_CTRL 2'h2

// ****************************************************************
// control register fields
// ****************************************************************
`define BEA_BIT_RDSTB 0
`define BEA_BIT_PEN 1
`define BEA_BIT_MPEN 2
`define BEA_BIT_RIE 3
`define BEA_BIT_PM_LO 4
`define BEA_BIT_PM_HI 5
`define BEA_MODE_RESET 2'h0

// ****************************************************************
// timing
// ****************************************************************
`define BEA_MPEN_WINDOW 4
`define BEA_PROG_STALL 2
`define BEA_READ_STALL 4
`define BEA_ATOMIC_US 3400
`define BEA_SPLIT_US 1800
`define BEA_OSC_KHZ 1000
`define BEA_ERASED 8'hFF

`endif

// ---- tb/bea_cpu_model.sv ----
// processor side model: register accesses and oscillator ticks
`timescale 1ns/1ns
module bea_cpu_model (
  input wire logic mclk,
  input wire logic cpu_stall,
  input wire logic [7:0] io_rdata,
  output logic io_wr,
  output logic io_rd,
  output logic [1:0] io_addr,
  output logic [7:0] io_wdata,
  output logic osc_tick
);
  // ****************************************
  // oscillator tick every 4 clocks
  // ****************************************
  int ph = 0;
  // halts that never ended, counted as mismatches by the bench
  int timeouts = 0;
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 2'h3;
    io_wdata = 8'h5A;
    osc_tick = 1'b0;
  end
  always @(posedge mclk) begin
    #1;
    ph = (ph + 1) % 4;
    osc_tick = (ph == 0);
  end
  // ****************************************
  // bus cycles
  // ****************************************
  task automatic start(input logic [1:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    // a halted core issues nothing
    while (cpu_stall !== 1'b0 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (cpu_stall !== 1'b0)
      timeouts++;
    io_addr = a;
  endtask : start
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    start(a);
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge mclk);
    #1;
    io_wr = 1'b0;
    io_wdata = ~d; // released bus shows no stale data
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    start(a);
    io_rd = 1'b1;
    @(posedge mclk);
    #1;
    io_rd = 1'b0;
    d = io_rdata;
  endtask : rd
endmodule : bea_cpu_model

// ---- tb/test_byte_eeprom_access_controller.sv ----
// self-checking bench of the nvm byte access controller
`timescale 1ns/1ns
`include "bea_regs.svh"
module test_byte_eeprom_access_controller;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic gie = 1'b0;
  logic io_wr, io_rd, osc_tick, cpu_stall, ready_irq;
  logic [1:0] io_addr;
  logic [7:0] io_wdata, io_rdata, v;
  int err_total = 0;
  int checked = 0;
  int stl = 0;
  int cyc = 0;
  int s0, t0;
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cpu_stall === 1'b1)
      stl <= stl + 1;
  end
  bea_ctrl #(.OSC_KHZ(10)) bea_ctrl_i (.mclk(mclk), .rst(rst),
    .osc_tick(osc_tick), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .global_int_en(gie),
    .io_rdata(io_rdata), .cpu_stall(cpu_stall), .ready_irq(ready_irq));
  bea_cpu_model bea_cpu_model_i (.mclk(mclk), .cpu_stall(cpu_stall),
    .io_rdata(io_rdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .osc_tick(osc_tick));
  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_cnt(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("CHECK FAILED at %0t: count %0d", $time, got);
    end
  endtask : chk_cnt
  task automatic final_report();
    err_total = err_total + bea_cpu_model_i.timeouts;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bea_cpu_model_i.wr(a, d);
  endtask : wr
  task automatic rc(input logic [7:0] e);
    bea_cpu_model_i.rd(`BEA_OFF_CTRL, v);
    chk(v, e);
  endtask : rc
  task automatic wait_idle();
    v = 8'h02;
    while (v[1] !== 1'b0) begin
      if (cyc - t0 > 400) begin
        err_total++;
        final_report();
      end
      bea_cpu_model_i.rd(`BEA_OFF_CTRL, v);
    end
  endtask : wait_idle
  // ****************************************
  // one program operation with probes while busy
  // ****************************************
  task automatic run(input logic [5:0] a, input logic [7:0] d,
    input logic [1:0] m, input logic [7:0] e);
    int tk;
    tk = ((m == 2'h0) ? `BEA_ATOMIC_US : `BEA_SPLIT_US) * 10 / 1000 * 4;
    wr(`BEA_OFF_ADDR, {2'h3, a});
    wr(`BEA_OFF_DATA, d);
    wr(`BEA_OFF_CTRL, {2'h0, m, 4'h0});
    wr(`BEA_OFF_CTRL, {2'h0, m, 4'h4});
    s0 = stl;
    wr(`BEA_OFF_CTRL, {2'h0, m, 4'h2});
    t0 = cyc;
    rc({2'h0, m, 4'h2});
    wr(`BEA_OFF_ADDR, 8'h3F);
    wr(`BEA_OFF_CTRL, {2'h0, ~m, 4'h1});
    rc({2'h0, m, 4'h2});
    bea_cpu_model_i.rd(`BEA_OFF_DATA, v);
    chk(v, d);
    bea_cpu_model_i.rd(`BEA_OFF_ADDR, v);
    chk(v, {2'h0, a});
    wait_idle();
    chk_cnt(cyc - t0, tk - 4, tk + 24);
    chk_cnt(stl - s0, 2, 2);
    s0 = stl;
    wr(`BEA_OFF_CTRL, {2'h0, m, 4'h1});
    bea_cpu_model_i.rd(`BEA_OFF_DATA, v);
    chk(v, e);
    chk_cnt(stl - s0, 4, 4);
    rc({2'h0, m, 4'h0});
    $display("test program mode %0d done", m);
  endtask : run
  initial begin
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    bea_cpu_model_i.rd(`BEA_OFF_CTRL, v);
    chk(v, 8'h00);
    run(6'h05, 8'hA5, 2'h0, 8'hA5);
    run(6'h05, 8'h3C, 2'h1, 8'hFF);
    run(6'h05, 8'h3C, 2'h2, 8'h3C);
    wr(`BEA_OFF_CTRL, 8'h02);
    rc(8'h00);
    wr(`BEA_OFF_CTRL, 8'h04);
    rc(8'h04);
    repeat (6) @(posedge mclk);
    rc(8'h00);
    wr(`BEA_OFF_CTRL, 8'h02);
    rc(8'h00);
    wr(`BEA_OFF_CTRL, 8'h34);
    wr(`BEA_OFF_CTRL, 8'h32);
    // master window is still open at this read
    rc(8'h34);
    $display("test guard done");
    wr(`BEA_OFF_ADDR, 8'h07);
    wr(`BEA_OFF_CTRL, 8'h14);
    wr(`BEA_OFF_CTRL, 8'h12);
    t0 = cyc;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    rc(8'h12);
    wait_idle();
    wr(`BEA_OFF_CTRL, 8'h01);
    bea_cpu_model_i.rd(`BEA_OFF_DATA, v);
    chk(v, 8'hFF);
    wr(`BEA_OFF_CTRL, 8'h20);
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    rc(8'h00);
    $display("test reset done");
    gie = 1'b1;
    wr(`BEA_OFF_CTRL, 8'h08);
    repeat (2) @(posedge mclk);
    #1;
    chk({7'h0, ready_irq}, 8'h01);
    gie = 1'b0;
    wr(`BEA_OFF_CTRL, 8'h1C);
    chk({7'h0, ready_irq}, 8'h00);
    wr(`BEA_OFF_CTRL, 8'h1A);
    t0 = cyc;
    gie = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk({7'h0, ready_irq}, 8'h00);
    wait_idle();
    repeat (2) @(posedge mclk);
    #1;
    chk({7'h0, ready_irq}, 8'h01);
    $display("test ready done");
    final_report();
  end
endmodule : test_byte_eeprom_access_controller
